// ### dao_top.sv
// How it works
// - offset binary runs 000 at minus full scale, 800 at zero, FFF at plus
// - strap at two-thirds or full supply gives two's complement, msb inverted
// - strap at ground or one-third supply gives offset binary
// - stabilizer on at one-third and two-thirds levels, off otherwise
// - one strap setting governs both channels together
// - overrange flag high and code clamped to full scale beyond limits
// - disabled output enable puts channel bus and flag in high impedance
// - each bus has its own output enable
// - power-down low means normal conversion
// - power-down with enable off means sleep, slow millisecond recovery
// - power-down with enable on means nap, recovery after 100 sample clocks
// - sleep and nap force that channel's outputs to high impedance
// - each channel's power state depends only on its own controls
// - swap select high routes channel A to bus A, B to bus B
// - swap select low exchanges the buses with their flags
// - stabilizer samples on rising edge and locks after about 100 cycles
`timescale 1ns/1ps
`default_nettype none
module dao_top #(
  parameter int unsigned SLEEP_WAKE_CYC = dao_pkg::SLEEP_WAKE_US * dao_pkg::SYS_CLK_MHZ
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic [4:0]                    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  input  wire logic [31:0]                   avs_writedata_i,
  output logic [31:0]                        avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic                          sample_clock_a_i,
  input  wire logic                          sample_clock_b_i,
  input  wire logic                          bus_swap_select_i,
  input  wire dao_pkg::dao_raw_t             raw_a_i,
  input  wire dao_pkg::dao_raw_t             raw_b_i,
  output logic [dao_pkg::CODE_W-1:0]         out_bus_a_o,
  output logic                               overrange_flag_a_o,
  output logic                               out_bus_a_oe_o,
  output logic [dao_pkg::CODE_W-1:0]         out_bus_b_o,
  output logic                               overrange_flag_b_o,
  output logic                               out_bus_b_oe_o
);

  typedef struct packed {
    dao_pkg::dao_pwr_t                          pwr;
    logic                                       from_sleep;
    logic [dao_pkg::WAKE_W-1:0]                 wake_cnt;
    logic [dao_pkg::LOCK_W-1:0]                 lock_cnt;
    logic [dao_pkg::STOP_W-1:0]                 stop_cnt;
    logic                                       clk_prev;
    dao_pkg::dao_word_t [dao_pkg::PIPE_LAT-1:0] pipe;
    dao_pkg::dao_word_t                         word;
  } dao_chan_t;

  typedef struct packed {
    dao_chan_t [1:0]              ch;
    logic [dao_pkg::CTRL_W-1:0]   ctrl;
    logic                         ack;
    logic [31:0]                  rdata;
  } dao_state_t;

  localparam logic [dao_pkg::WAKE_W-1:0] SLEEP_CNT = SLEEP_WAKE_CYC[dao_pkg::WAKE_W-1:0];
  localparam logic [dao_pkg::WAKE_W-1:0] NAP_CNT   = dao_pkg::NAP_WAKE_EDGES[dao_pkg::WAKE_W-1:0];
  localparam logic [dao_pkg::LOCK_W-1:0] LOCK_DONE = dao_pkg::DCS_LOCK_EDGES[dao_pkg::LOCK_W-1:0];
  localparam logic [dao_pkg::STOP_W-1:0] STOP_DONE = dao_pkg::CLK_STOP_CYC[dao_pkg::STOP_W-1:0];

  dao_state_t state_ff;
  dao_state_t nxt_state;

  // outputs powered and converting
  function automatic logic awake(input dao_pkg::dao_pwr_t p);
    awake = (p == dao_pkg::pwr_run) || (p == dao_pkg::pwr_wake);
  endfunction : awake

  // clamp, flag and format one converter result
  function automatic dao_pkg::dao_word_t encode(input dao_pkg::dao_raw_t r,
                                                input logic twos);
    dao_pkg::dao_word_t w;
    w.ovr  = r.hi | r.lo;
    w.code = r.hi ? dao_pkg::CODE_MAX : (r.lo ? dao_pkg::CODE_MIN : r.code);
    if (twos) begin
      w.code = w.code ^ dao_pkg::CODE_MSB;
    end
    encode = w;
  endfunction : encode

  logic [1:0]          mode;
  logic                twos_fmt;
  logic                dcs_en;
  logic [1:0]          clk_in;
  logic [1:0]          edge_seen;
  logic [1:0]          ch_valid;
  logic [1:0]          ch_locked;
  dao_pkg::dao_raw_t   raw [2];
  logic                req;

  assign mode     = state_ff.ctrl[dao_pkg::CTRL_MODE +: 2];
  assign twos_fmt = (mode == dao_pkg::MODE_TWO3) ||
                    (mode == dao_pkg::MODE_VDD);
  assign dcs_en   = (mode == dao_pkg::MODE_THIRD) ||
                    (mode == dao_pkg::MODE_TWO3);
  assign clk_in   = {sample_clock_b_i, sample_clock_a_i};
  assign raw[0]   = raw_a_i;
  assign raw[1]   = raw_b_i;
  assign req      = avs_read_i | avs_write_i;

  always_comb begin
    logic pd;
    logic oen;
    pd        = 1'b0;
    oen       = 1'b0;
    nxt_state = state_ff;
    edge_seen = 2'b00;
    ch_valid  = 2'b00;
    ch_locked = 2'b00;
    for (int c = 0; c < 2; c++) begin
      pd  = state_ff.ctrl[dao_pkg::CTRL_PD_A + c];
      oen = state_ff.ctrl[dao_pkg::CTRL_OEN_A + c];
      // rising edge only, falling edge ignored
      edge_seen[c] = clk_in[c] & ~state_ff.ch[c].clk_prev;
      nxt_state.ch[c].clk_prev = clk_in[c];
      if (edge_seen[c]) begin
        nxt_state.ch[c].stop_cnt = '0;
      end else if (state_ff.ch[c].stop_cnt != STOP_DONE) begin
        nxt_state.ch[c].stop_cnt = state_ff.ch[c].stop_cnt + 1'b1;
      end
      // stabilizer relocks after power-down or a stopped clock
      if (pd || (state_ff.ch[c].stop_cnt == STOP_DONE)) begin
        nxt_state.ch[c].lock_cnt = '0;
      end else if (edge_seen[c] && (state_ff.ch[c].lock_cnt != LOCK_DONE)) begin
        nxt_state.ch[c].lock_cnt = state_ff.ch[c].lock_cnt + 1'b1;
      end
      ch_locked[c] = state_ff.ch[c].lock_cnt == LOCK_DONE;
      unique case (state_ff.ch[c].pwr)
        dao_pkg::pwr_run, dao_pkg::pwr_wake: begin
          if (pd) begin
            nxt_state.ch[c].pwr = oen ? dao_pkg::pwr_sleep : dao_pkg::pwr_nap;
          end else if (state_ff.ch[c].pwr == dao_pkg::pwr_wake) begin
            if (state_ff.ch[c].wake_cnt == '0) begin
              nxt_state.ch[c].pwr = dao_pkg::pwr_run;
            end else if (state_ff.ch[c].from_sleep || edge_seen[c]) begin
              nxt_state.ch[c].wake_cnt = state_ff.ch[c].wake_cnt - 1'b1;
            end
          end
        end
        dao_pkg::pwr_nap: begin
          if (pd && oen) begin
            nxt_state.ch[c].pwr = dao_pkg::pwr_sleep;
          end else if (!pd) begin
            nxt_state.ch[c].pwr        = dao_pkg::pwr_wake;
            nxt_state.ch[c].from_sleep = 1'b0;
            nxt_state.ch[c].wake_cnt   = NAP_CNT;
          end
        end
        dao_pkg::pwr_sleep: begin
          if (pd && !oen) begin
            nxt_state.ch[c].pwr = dao_pkg::pwr_nap;
          end else if (!pd) begin
            nxt_state.ch[c].pwr        = dao_pkg::pwr_wake;
            nxt_state.ch[c].from_sleep = 1'b1;
            nxt_state.ch[c].wake_cnt   = SLEEP_CNT;
          end
        end
      endcase
      ch_valid[c] = (state_ff.ch[c].pwr == dao_pkg::pwr_run) && (!dcs_en || ch_locked[c]);
      // one new word per sample clock after the pipeline
      if (edge_seen[c] && awake(state_ff.ch[c].pwr)) begin
        nxt_state.ch[c].pipe[0] = encode(raw[c], twos_fmt);
        for (int i = 1; i < dao_pkg::PIPE_LAT; i++) begin
          nxt_state.ch[c].pipe[i] = state_ff.ch[c].pipe[i-1];
        end
        nxt_state.ch[c].word = state_ff.ch[c].pipe[dao_pkg::PIPE_LAT-1];
      end
    end
    // avalon slave: one wait state, read data loaded before the release edge
    nxt_state.ack = req & ~state_ff.ack;
    if (req && !state_ff.ack) begin
      nxt_state.rdata = '0;
      unique case (avs_address_i)
        dao_pkg::OFS_CTRL: begin
          nxt_state.rdata[dao_pkg::CTRL_W-1:0] = state_ff.ctrl;
        end
        dao_pkg::OFS_STATUS: begin
          for (int c = 0; c < 2; c++) begin
            nxt_state.rdata[dao_pkg::ST_PWR_LSB + 2*c +: 2] = state_ff.ch[c].pwr;
            nxt_state.rdata[dao_pkg::ST_VALID_LSB + c]      = ch_valid[c];
            nxt_state.rdata[dao_pkg::ST_LOCK_LSB + c]       = ch_locked[c];
          end
          nxt_state.rdata[dao_pkg::ST_DCS]  = dcs_en;
          nxt_state.rdata[dao_pkg::ST_TWOS] = twos_fmt;
        end
        dao_pkg::OFS_DATA_A: begin
          nxt_state.rdata[dao_pkg::CODE_W:0] = state_ff.ch[0].word;
        end
        dao_pkg::OFS_DATA_B: begin
          nxt_state.rdata[dao_pkg::CODE_W:0] = state_ff.ch[1].word;
        end
        default: begin
          nxt_state.rdata = '0;
        end
      endcase
    end
    if (avs_write_i && state_ff.ack && avs_byteenable_i[0] &&
        (avs_address_i == dao_pkg::OFS_CTRL)) begin
      nxt_state.ctrl = avs_writedata_i[dao_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff      <= '0;
      state_ff.ctrl <= dao_pkg::CTRL_RESET;
      for (int c = 0; c < 2; c++) begin
        state_ff.ch[c].pwr <= dao_pkg::pwr_run;
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign avs_waitrequest_o = req & ~state_ff.ack;
  assign avs_readdata_o    = state_ff.rdata;

  dao_pkg::dao_word_t bus_a_word;
  dao_pkg::dao_word_t bus_b_word;
  assign bus_a_word = bus_swap_select_i ? state_ff.ch[0].word
                                        : state_ff.ch[1].word;
  assign bus_b_word = bus_swap_select_i ? state_ff.ch[1].word
                                        : state_ff.ch[0].word;

  assign out_bus_a_o        = bus_a_word.code;
  assign overrange_flag_a_o = bus_a_word.ovr;
  assign out_bus_b_o        = bus_b_word.code;
  assign overrange_flag_b_o = bus_b_word.ovr;
  // enable for data and flag together, forced off in nap and sleep
  assign out_bus_a_oe_o = ~state_ff.ctrl[dao_pkg::CTRL_OEN_A] &
                          awake(state_ff.ch[0].pwr);
  assign out_bus_b_oe_o = ~state_ff.ctrl[dao_pkg::CTRL_OEN_A + 1] &
                          awake(state_ff.ch[1].pwr);

  logic [1:0] bus_oe;
  assign bus_oe = {out_bus_b_oe_o, out_bus_a_oe_o};

  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_hiz_powered_down: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ch[g].pwr inside {dao_pkg::pwr_nap, dao_pkg::pwr_sleep}) |-> !bus_oe[g])
      else $error("bus driven while channel powered down");
    a_oe_disables_bus: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_ff.ctrl[dao_pkg::CTRL_OEN_A + g] |-> !bus_oe[g])
      else $error("bus driven with enable off");
    a_sleep_entry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ctrl[dao_pkg::CTRL_PD_A + g] && state_ff.ctrl[dao_pkg::CTRL_OEN_A + g])
      |=> state_ff.ch[g].pwr == dao_pkg::pwr_sleep)
      else $error("sleep not entered");
    a_nap_entry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ctrl[dao_pkg::CTRL_PD_A + g] && !state_ff.ctrl[dao_pkg::CTRL_OEN_A + g])
      |=> state_ff.ch[g].pwr == dao_pkg::pwr_nap)
      else $error("nap not entered");
    a_nap_wake_count: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ch[g].pwr == dao_pkg::pwr_nap && !state_ff.ctrl[dao_pkg::CTRL_PD_A + g])
      |=> (state_ff.ch[g].pwr == dao_pkg::pwr_wake) && (state_ff.ch[g].wake_cnt == NAP_CNT))
      else $error("nap exit did not load 100 edges");
    a_wake_to_run: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ch[g].pwr == dao_pkg::pwr_wake && state_ff.ch[g].wake_cnt == '0 &&
       !state_ff.ctrl[dao_pkg::CTRL_PD_A + g]) |=> state_ff.ch[g].pwr == dao_pkg::pwr_run)
      else $error("recovery did not end in run");
    a_ovr_clamped: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_ff.ch[g].word.ovr |-> (state_ff.ch[g].word.code[dao_pkg::CODE_W-2:0] == '1 ||
                                   state_ff.ch[g].word.code[dao_pkg::CODE_W-2:0] == '0))
      else $error("overrange word not at full scale");
    a_edge_update: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (edge_seen[g] && awake(state_ff.ch[g].pwr))
      |=> state_ff.ch[g].word == $past(state_ff.ch[g].pipe[dao_pkg::PIPE_LAT-1]))
      else $error("word did not advance on sample edge");
    a_word_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !edge_seen[g] |=> $stable(state_ff.ch[g].word))
      else $error("word changed without a sample edge");
    a_asleep_frozen: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ch[g].pwr inside {dao_pkg::pwr_nap, dao_pkg::pwr_sleep})
      |=> $stable(state_ff.ch[g].word))
      else $error("word changed while powered down");
    a_lock_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      state_ff.ctrl[dao_pkg::CTRL_PD_A + g] |=> state_ff.ch[g].lock_cnt == '0)
      else $error("lock kept through power-down");
    a_lock_count: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (edge_seen[g] && !state_ff.ctrl[dao_pkg::CTRL_PD_A + g] &&
       state_ff.ch[g].stop_cnt != STOP_DONE && state_ff.ch[g].lock_cnt != LOCK_DONE)
      |=> state_ff.ch[g].lock_cnt == $past(state_ff.ch[g].lock_cnt) + 1'b1)
      else $error("lock count missed a rising edge");
    a_run_own_ctrl: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (state_ff.ch[g].pwr == dao_pkg::pwr_run && !state_ff.ctrl[dao_pkg::CTRL_PD_A + g])
      |=> state_ff.ch[g].pwr == dao_pkg::pwr_run)
      else $error("running channel left run");
    a_oe_enables_bus: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (!state_ff.ctrl[dao_pkg::CTRL_OEN_A + g] && awake(state_ff.ch[g].pwr)) |-> bus_oe[g])
      else $error("enabled bus not driven");
    a_flag_entry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (edge_seen[g] && awake(state_ff.ch[g].pwr))
      |=> state_ff.ch[g].pipe[0].ovr == ($past(raw[g].hi) || $past(raw[g].lo)))
      else $error("overrange flag wrong on entry");
    a_code_format: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (edge_seen[g] && awake(state_ff.ch[g].pwr) && !raw[g].hi && !raw[g].lo)
      |=> state_ff.ch[g].pipe[0].code ==
          ($past(raw[g].code) ^ ($past(twos_fmt) ? dao_pkg::CODE_MSB : dao_pkg::CODE_MIN)))
      else $error("sample code format wrong");
  end

  a_swap_route: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !bus_swap_select_i |-> (out_bus_b_o == state_ff.ch[0].word.code &&
                            overrange_flag_a_o == state_ff.ch[1].word.ovr))
    else $error("swap low did not exchange buses");
  a_dcs_strap: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    dcs_en == (mode[0] ^ mode[1]))
    else $error("stabilizer select wrong");
  a_bus_answer: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("avalon answer late");
  a_swap_direct: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    bus_swap_select_i |-> (out_bus_a_o == state_ff.ch[0].word.code &&
                           overrange_flag_a_o == state_ff.ch[0].word.ovr &&
                           out_bus_b_o == state_ff.ch[1].word.code))
    else $error("swap high did not route straight");
  a_ctrl_write: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
     avs_address_i == dao_pkg::OFS_CTRL)
    |=> state_ff.ctrl == $past(avs_writedata_i[dao_pkg::CTRL_W-1:0]))
    else $error("control write lost");

  c_nap_recover: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state_ff.ch[0].pwr == dao_pkg::pwr_wake ##1 state_ff.ch[0].pwr == dao_pkg::pwr_run);
  c_sleep_seen: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state_ff.ch[1].pwr == dao_pkg::pwr_sleep);
  c_swapped_ovr: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !bus_swap_select_i && overrange_flag_a_o && out_bus_a_oe_o);
  c_locked_twos: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    twos_fmt && ch_valid[0]);
  c_interleave: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    out_bus_a_oe_o && !out_bus_b_oe_o && bus_swap_select_i ##1 !bus_swap_select_i);

endmodule : dao_top
`default_nettype wire

// ### dao_pkg.sv
`default_nettype none
package dao_pkg;

  localparam int unsigned SYS_CLK_MHZ    = 100;
  localparam int unsigned CODE_W         = 12;
  localparam int unsigned PIPE_LAT       = 6;

  // recovery and lock figures
  localparam int unsigned NAP_WAKE_EDGES = 100;
  localparam int unsigned DCS_LOCK_EDGES = 100;
  localparam int unsigned SLEEP_WAKE_US  = 2000;
  localparam int unsigned CLK_STOP_NS    = 1000;
  localparam int unsigned CLK_STOP_CYC   = (CLK_STOP_NS * SYS_CLK_MHZ) / 1000;

  localparam int unsigned WAKE_W = 18;
  localparam int unsigned LOCK_W = 7;
  localparam int unsigned STOP_W = 7;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_DATA_A = 5'h08;
  localparam logic [4:0] OFS_DATA_B = 5'h0C;

  // control fields
  localparam int unsigned CTRL_W      = 6;
  localparam int unsigned CTRL_MODE   = 0;
  localparam int unsigned CTRL_PD_A   = 2;
  localparam int unsigned CTRL_OEN_A  = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h30;

  // strap levels
  localparam logic [1:0] MODE_GND   = 2'h0;
  localparam logic [1:0] MODE_THIRD = 2'h1;
  localparam logic [1:0] MODE_TWO3  = 2'h2;
  localparam logic [1:0] MODE_VDD   = 2'h3;

  // status fields
  localparam int unsigned ST_PWR_LSB   = 0;
  localparam int unsigned ST_VALID_LSB = 4;
  localparam int unsigned ST_DCS       = 6;
  localparam int unsigned ST_TWOS      = 7;
  localparam int unsigned ST_LOCK_LSB  = 8;

  localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;

  typedef enum logic [1:0] {
    pwr_run   = 2'h0,
    pwr_nap   = 2'h1,
    pwr_sleep = 2'h2,
    pwr_wake  = 2'h3
  } dao_pwr_t;

  typedef struct packed {
    logic              hi;
    logic              lo;
    logic [CODE_W-1:0] code;
  } dao_raw_t;

  typedef struct packed {
    logic              ovr;
    logic [CODE_W-1:0] code;
  } dao_word_t;

endpackage : dao_pkg
`default_nettype wire

// ### dao_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module dao_capture_model (
  input  wire logic        sys_clk_i,
  input  wire logic        interleave_i,
  input  wire logic        swap_static_i,
  input  wire logic [11:0] bus_i,
  input  wire logic        ovr_i,
  input  wire logic        oe_i,
  output logic             sample_clock_a_o,
  output logic             sample_clock_b_o,
  output logic             bus_swap_select_o,
  output logic [12:0]      cap_hi_o,
  output logic [12:0]      cap_lo_o
);
  logic sclk_ff = 1'b0;

  // one source feeds both sample clocks
  assign sample_clock_a_o  = sclk_ff;
  assign sample_clock_b_o  = sclk_ff;
  // interleave: swap select follows the sample clock
  assign bus_swap_select_o = interleave_i ? sclk_ff : swap_static_i;

  // capture the shared bus in each clock phase
  always @(posedge sys_clk_i) begin
    if (oe_i && sclk_ff) begin
      cap_hi_o <= {ovr_i, bus_i};
    end else if (oe_i) begin
      cap_lo_o <= {ovr_i, bus_i};
    end
  end

  // sample clock runs only inside bursts, two cycles high and two low
  task pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      sclk_ff <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sclk_ff <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask : pulses
endmodule : dao_capture_model
`default_nettype wire

// ### dual_adc_output_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_control_tb_top;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [4:0]        addr = 5'h00;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [3:0]        be = 4'h0;
  logic [31:0]       wdata = 32'h0;
  logic [31:0]       rdata;
  logic              waitreq;
  logic              scl_a, scl_b, swap;
  logic              ilv = 1'b0;
  logic              swap_st = 1'b1;
  dao_pkg::dao_raw_t raw_a = '0;
  dao_pkg::dao_raw_t raw_b = '0;
  logic [11:0]       bus_a, bus_b;
  logic              ovr_a, ovr_b, oe_a, oe_b;
  logic [12:0]       cap_hi, cap_lo;
  logic [31:0]       q;
  logic              tw, dc;
  int                mismatches = 0;
  int                cmp_count = 0;

  always #5 clk = ~clk;

  dao_top #(.SLEEP_WAKE_CYC(20)) dao_top_inst (
    .sys_clk_i(clk), .resetn_i(rstn), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .sample_clock_a_i(scl_a), .sample_clock_b_i(scl_b), .bus_swap_select_i(swap),
    .raw_a_i(raw_a), .raw_b_i(raw_b),
    .out_bus_a_o(bus_a), .overrange_flag_a_o(ovr_a), .out_bus_a_oe_o(oe_a),
    .out_bus_b_o(bus_b), .overrange_flag_b_o(ovr_b), .out_bus_b_oe_o(oe_b));

  dao_capture_model dao_capture_model_inst (
    .sys_clk_i(clk), .interleave_i(ilv), .swap_static_i(swap_st), .bus_i(bus_a),
    .ovr_i(ovr_a), .oe_i(oe_a), .sample_clock_a_o(scl_a), .sample_clock_b_o(scl_b),
    .bus_swap_select_o(swap), .cap_hi_o(cap_hi), .cap_lo_o(cap_lo));

  function automatic logic [12:0] fmt(input dao_pkg::dao_raw_t r, input logic twos);
    logic [11:0] c;
    c = r.hi ? dao_pkg::CODE_MAX : (r.lo ? dao_pkg::CODE_MIN : r.code);
    return {r.hi | r.lo, c ^ (twos ? dao_pkg::CODE_MSB : 12'h000)};
  endfunction : fmt

  task results;
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    rd    <= ~w;
    wr    <= w;
    wdata <= d;
    be    <= b;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      results();
    end
  endtask : bus

  // one more edge so the written control shows on the outputs
  task ctrl(input logic [31:0] v);
    bus(dao_pkg::OFS_CTRL, 1'b1, v, 4'hF);
    @(posedge clk);
  endtask : ctrl

  task status;
    bus(dao_pkg::OFS_STATUS, 1'b0, 32'h0, 4'hF);
  endtask : status

  task pulse(input int n);
    dao_capture_model_inst.pulses(n);
    repeat (2) @(posedge clk);
  endtask : pulse

  initial begin
    #200_000;
    mismatches++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    chk(32'(oe_a), 32'h0);
    bus(dao_pkg::OFS_CTRL, 1'b0, 32'h0, 4'hF);
    chk(q, 32'(dao_pkg::CTRL_RESET));
    bus(5'h10, 1'b0, 32'h0, 4'hF);
    chk(q, 32'h0);
    bus(dao_pkg::OFS_CTRL, 1'b1, 32'h0, 4'h0);
    bus(dao_pkg::OFS_CTRL, 1'b0, 32'h0, 4'hF);
    chk(q, 32'(dao_pkg::CTRL_RESET));
    // every strap level on both channels
    for (int m = 0; m < 4; m++) begin
      tw = (m >= 2);
      dc = (m == 1) || (m == 2);
      ctrl(32'(m));
      raw_a <= {2'b00, 12'h800};
      raw_b <= {2'b00, (m[0] ? 12'hFFF : 12'h001)};
      pulse(110);
      chk(32'({ovr_a, bus_a}), 32'(fmt(raw_a, tw)));
      chk(32'({ovr_b, bus_b}), 32'(fmt(raw_b, tw)));
      status();
      chk(32'(q[7:6]), 32'({tw, dc}));
      if (dc) chk(32'(q[8]), 32'h1);
    end
    // fixed latency through the sample pipeline
    ctrl(32'h0);
    raw_a <= {2'b00, 12'h111};
    pulse(8);
    raw_a <= {2'b00, 12'h222};
    pulse(6);
    chk(32'(bus_a), 32'h111);
    pulse(1);
    chk(32'(bus_a), 32'h222);
    // overrange clamps in two's complement
    ctrl(32'h3);
    raw_a <= {2'b10, 12'h123};
    raw_b <= {2'b01, 12'h456};
    pulse(8);
    chk(32'({ovr_a, bus_a}), 32'h17FF);
    chk(32'({ovr_b, bus_b}), 32'h1800);
    bus(dao_pkg::OFS_DATA_A, 1'b0, 32'h0, 4'hF);
    chk(q, 32'h17FF);
    swap_st <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({ovr_a, bus_a}), 32'(fmt(raw_b, 1'b1)));
    chk(32'({ovr_b, bus_b}), 32'(fmt(raw_a, 1'b1)));
    swap_st <= 1'b1;
    // separate enables per bus, changed only while sample clocks stand still
    ctrl(32'h10);
    chk(32'({oe_a, oe_b}), 32'h1);
    ctrl(32'h20);
    chk(32'({oe_a, oe_b}), 32'h2);
    // nap on channel A, B keeps running
    ctrl(32'h04);
    status();
    chk(32'(q[3:0]), 32'h1);
    chk(32'({oe_a, oe_b}), 32'h1);
    ctrl(32'h0);
    status();
    chk(32'(q[1:0]), 32'h3);
    pulse(90);
    status();
    chk(32'(q[1:0]), 32'h3);
    pulse(15);
    status();
    chk(32'({q[1:0], oe_a}), 32'h1);
    // sleep on channel A
    ctrl(32'h14);
    status();
    chk(32'({q[1:0], oe_a}), 32'h4);
    ctrl(32'h10);
    status();
    chk(32'(q[1:0]), 32'h3);
    repeat (30) @(posedge clk);
    status();
    chk(32'(q[1:0]), 32'h0);
    // interleave both channels onto bus A, bus B off
    ctrl(32'h20);
    raw_a <= {2'b00, 12'h0AA};
    raw_b <= {2'b00, 12'h155};
    ilv <= 1'b1;
    pulse(8);
    chk(32'(cap_hi), 32'h00AA);
    chk(32'(cap_lo), 32'h0155);
    ilv <= 1'b0;
    results();
  end
endmodule : dual_adc_output_control_tb_top
`default_nettype wire
